// ### ppfm_top.sv
// two gpio ports with peripheral function mux, avalon registers, irq
// Behaviour
// - each bit has all controls; direction always from register
// - p1 bit0 outputs low, input clocks timer
// - p1 bits1-3 compare out, capture A in
// - p1 bit4 outputs subsystem clock, input unused
// - p1 bits5-7 output compares, input unused
// - p2 bit0 outputs auxiliary clock, input unused
// - p2 bit1 outputs low, input alternate clock
// - p2 bit2 comparator out, capture B in
// - p2 bits3-4 output compares b and c
// - p2 bits6-7 unbonded, output low, no input
// - unbonded flags change by software only
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module ppfm_top (
	input  wire logic                  i_clk,           // 200 MHz
	input  wire logic                  i_rst,           // async, high
	// avalon-mm slave
	input  wire logic [7:0]            i_avs_address,   // byte address
	input  wire logic                  i_avs_read,      // read request
	input  wire logic                  i_avs_write,     // write request
	input  wire logic [31:0]           i_avs_writedata, // write data
	input  wire logic [3:0]            i_avs_byteenable,// byte lanes
	output logic      [31:0]           o_avs_readdata,  // read data
	output logic                       o_avs_waitrequest, // stall
	output logic                       o_irq,           // level irq
	// pins
	input  wire logic [7:0]            i_p1_pin,        // port one in
	output logic      [7:0]            o_p1_pin_out,    // port one out
	output logic      [7:0]            o_p1_pin_oe_n,   // low drives
	input  wire logic [5:0]            i_p2_pin,        // port two in
	output logic      [5:0]            o_p2_pin_out,    // port two out
	output logic      [5:0]            o_p2_pin_oe_n,   // low drives
	// peripheral sources
	input  wire logic                  i_timer_compare_a,
	input  wire logic                  i_timer_compare_b,
	input  wire logic                  i_timer_compare_c,
	input  wire logic                  i_subsystem_clock,
	input  wire logic                  i_auxiliary_clock,
	input  wire logic                  i_comparator_result,
	// peripheral destinations
	output logic                       o_timer_ext_clock_in,
	output logic                       o_capture_in_ch0_a,
	output logic                       o_capture_in_ch1_a,
	output logic                       o_capture_in_ch2_a,
	output logic                       o_timer_alt_clock_in,
	output logic                       o_capture_in_ch0_b
);
	// whole state of the top
	typedef struct packed {
		logic [1:0][7:0] sel;      // pin_function_select per port
		logic [1:0][7:0] dir;      // pin_direction per port
		logic [1:0][7:0] outv;     // pin_output_value per port
		logic [1:0][7:0] ie;       // pin_irq_enable per port
		logic [1:0][7:0] ies;      // pin_edge_select per port
		logic [7:0]      p1_out;   // port one pin level
		logic [7:0]      p1_oe_n;  // port one enables
		logic [5:0]      p2_out;   // port two pin level
		logic [5:0]      p2_oe_n;  // port two enables
		logic            waitreq;  // avalon waitrequest
		logic [31:0]     rdata;    // avalon readdata
		logic            irq;      // interrupt output
	} ppfm_top_t;

	ppfm_top_t       st;       // registered state
	ppfm_top_t       next_st;  // next state
	logic [1:0][7:0] pins;     // pins per port, unbonded tied low
	logic [1:0][7:0] level;    // pin_input_value per port
	logic [1:0][7:0] flag;     // pin_irq_flag per port
	logic [1:0][7:0] clr;      // w1c pulses
	logic [1:0][7:0] setp;     // w1s pulses
	logic [1:0][7:0] periph;   // peripheral output path per port
	logic            access;   // request seen while stalled
	logic            take;     // access completes this edge
	logic            mapped;   // address decodes to a register
	logic            lane0;    // low byte enabled on write
	logic            port;     // addressed port
	logic [2:0]      regi;     // addressed register index

	// unbonded bits 6 and 7 of port two have no pin
	assign pins[0] = i_p1_pin;
	assign pins[1] = {2'b00, i_p2_pin};

	// address decode
	assign port   = i_avs_address[ppfm_pkg::PORT_POS];
	assign regi   = i_avs_address[ppfm_pkg::REG_MSB:ppfm_pkg::REG_LSB];
	assign mapped = (i_avs_address[ppfm_pkg::ALIGN_MSB:0] == 2'h0) &&
		(i_avs_address[7:ppfm_pkg::TOP_LSB] == 2'h0);
	assign access = (i_avs_read | i_avs_write) & st.waitreq;
	assign take   = (i_avs_read | i_avs_write) & ~st.waitreq;
	assign lane0  = i_avs_byteenable[0];

	// flag write pulses, only on the completing edge
	always_comb begin
		clr  = '0;
		setp = '0;
		if (take && i_avs_write && mapped && lane0) begin
			if (regi == ppfm_pkg::REG_IFG) begin
				clr[port] = i_avs_writedata[7:0];
			end
			if (regi == ppfm_pkg::REG_IFG_SET) begin
				setp[port] = i_avs_writedata[7:0];
			end
		end
	end

	// peripheral output path of every bit
	always_comb begin
		periph[0][0] = 1'b0;
		periph[0][1] = i_timer_compare_a;
		periph[0][2] = i_timer_compare_b;
		periph[0][3] = i_timer_compare_c;
		periph[0][4] = i_subsystem_clock;
		periph[0][5] = i_timer_compare_a;
		periph[0][6] = i_timer_compare_b;
		periph[0][7] = i_timer_compare_c;
		periph[1][0] = i_auxiliary_clock;
		periph[1][1] = 1'b0;
		periph[1][2] = i_comparator_result;
		periph[1][3] = i_timer_compare_b;
		periph[1][4] = i_timer_compare_c;
		periph[1][5] = 1'b0;
		periph[1][6] = 1'b0;
		periph[1][7] = 1'b0;
	end

	// one cell per port bit, full controls on all sixteen
	for (genvar p = 0; p < 2; p++) begin : g_port
		for (genvar b = 0; b < ppfm_pkg::PORT_W; b++) begin : g_bit
			ppfm_bit #(
				.BONDED (!(p == 1 && b >= ppfm_pkg::P2_PINS))
			) u_bit (
				.i_clk      (i_clk),
				.i_rst      (i_rst),
				.i_pin      (pins[p][b]),
				.i_edge_sel (st.ies[p][b]),
				.i_flag_clr (clr[p][b]),
				.i_flag_set (setp[p][b]),
				.o_level    (level[p][b]),
				.o_flag     (flag[p][b])
			);
		end
	end

	// next state: registers, pin mux, bus answer, interrupt
	always_comb begin
		logic [1:0][7:0] drive;
		logic [7:0]      rd;
		drive   = '0;
		rd      = 8'h00;
		next_st = st;
		// select picks the peripheral path, else the output register
		for (int p = 0; p < 2; p++) begin
			drive[p] = (st.sel[p] & periph[p]) |
				(~st.sel[p] & st.outv[p]);
		end
		next_st.p1_out  = drive[0];
		next_st.p2_out  = drive[1][5:0];
		// direction register rules even under peripheral select
		next_st.p1_oe_n = ~st.dir[0];
		next_st.p2_oe_n = ~st.dir[1][5:0];
		// software writes on the completing edge
		if (take && i_avs_write && mapped && lane0) begin
			case (regi)
				ppfm_pkg::REG_SEL: begin
					next_st.sel[port] = i_avs_writedata[7:0];
				end
				ppfm_pkg::REG_DIR: begin
					next_st.dir[port] = i_avs_writedata[7:0];
				end
				ppfm_pkg::REG_OUT: begin
					next_st.outv[port] = i_avs_writedata[7:0];
				end
				ppfm_pkg::REG_IE: begin
					next_st.ie[port] = i_avs_writedata[7:0];
				end
				ppfm_pkg::REG_IES: begin
					next_st.ies[port] = i_avs_writedata[7:0];
				end
				default: begin
					// input, flag and flag-set need no storage here
				end
			endcase
		end
		// read mux, captured while stalled
		case (regi)
			ppfm_pkg::REG_SEL: rd = st.sel[port];
			ppfm_pkg::REG_DIR: rd = st.dir[port];
			ppfm_pkg::REG_OUT: rd = st.outv[port];
			ppfm_pkg::REG_IN:  rd = level[port];
			ppfm_pkg::REG_IE:  rd = st.ie[port];
			ppfm_pkg::REG_IFG: rd = flag[port];
			ppfm_pkg::REG_IES: rd = st.ies[port];
			default:           rd = 8'h00;
		endcase
		if (access && i_avs_read) begin
			next_st.rdata = mapped ? {24'h000000, rd} :
				ppfm_pkg::RST_RDATA;
		end
		// one stall cycle, then one answer cycle
		next_st.waitreq = ~access;
		// level irq while any enabled flag stands
		next_st.irq = |(flag & st.ie);
	end

	// state register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st.sel     <= {2{ppfm_pkg::RST_CTRL}};
			st.dir     <= {2{ppfm_pkg::RST_CTRL}};
			st.outv    <= {2{ppfm_pkg::RST_CTRL}};
			st.ie      <= {2{ppfm_pkg::RST_CTRL}};
			st.ies     <= {2{ppfm_pkg::RST_CTRL}};
			st.p1_out  <= ppfm_pkg::RST_CTRL;
			st.p1_oe_n <= ppfm_pkg::RST_OE_N;
			st.p2_out  <= ppfm_pkg::RST_CTRL[5:0];
			st.p2_oe_n <= ppfm_pkg::RST_OE_N[5:0];
			st.waitreq <= 1'b1;
			st.rdata   <= ppfm_pkg::RST_RDATA;
			st.irq     <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// outputs
	assign o_avs_readdata       = st.rdata;
	assign o_avs_waitrequest    = st.waitreq;
	assign o_irq                = st.irq;
	assign o_p1_pin_out         = st.p1_out;
	assign o_p1_pin_oe_n        = st.p1_oe_n;
	assign o_p2_pin_out         = st.p2_out;
	assign o_p2_pin_oe_n        = st.p2_oe_n;
	// pin inputs routed to peripherals, straight from sync flops
	assign o_timer_ext_clock_in = level[0][0];
	assign o_capture_in_ch0_a   = level[0][1];
	assign o_capture_in_ch1_a   = level[0][2];
	assign o_capture_in_ch2_a   = level[0][3];
	assign o_timer_alt_clock_in = level[1][1];
	assign o_capture_in_ch0_b   = level[1][2];

	// enables follow direction one cycle later whatever the select
	property p_dir_oe;
		@(posedge i_clk) disable iff (i_rst)
		##1 (o_p1_pin_oe_n == ~$past(st.dir[0])) &&
			(o_p2_pin_oe_n == ~$past(st.dir[1][5:0]));
	endproperty
	a_dir_oe: assert property (p_dir_oe)
		else $error("pin enable does not follow direction");

	// bit 0 of port one drives low under select, clocks the timer
	property p_p1b0;
		@(posedge i_clk) disable iff (i_rst)
		st.sel[0][0] |=> !o_p1_pin_out[0] &&
			(o_timer_ext_clock_in == $past(i_p1_pin[0], 2));
	endproperty
	a_p1b0: assert property (p_p1b0)
		else $error("port one bit 0 function wrong");

	// compare b output and capture ch1 a input on port one bit 2
	property p_p1_cap;
		@(posedge i_clk) disable iff (i_rst)
		st.sel[0][2] |=> (o_p1_pin_out[2] == $past(i_timer_compare_b))
			&& (o_capture_in_ch1_a == $past(i_p1_pin[2], 2));
	endproperty
	a_p1_cap: assert property (p_p1_cap)
		else $error("port one bit 2 compare or capture wrong");

	// subsystem clock on port one bit 4
	property p_p1b4;
		@(posedge i_clk) disable iff (i_rst)
		st.sel[0][4] |=> o_p1_pin_out[4] == $past(i_subsystem_clock);
	endproperty
	a_p1b4: assert property (p_p1b4)
		else $error("port one bit 4 not the subsystem clock");

	// compare c on port one bit 7
	property p_p1b7;
		@(posedge i_clk) disable iff (i_rst)
		st.sel[0][7] |=> o_p1_pin_out[7] == $past(i_timer_compare_c);
	endproperty
	a_p1b7: assert property (p_p1b7)
		else $error("port one bit 7 not compare c");

	// auxiliary clock on port two bit 0
	property p_p2b0;
		@(posedge i_clk) disable iff (i_rst)
		st.sel[1][0] |=> o_p2_pin_out[0] == $past(i_auxiliary_clock);
	endproperty
	a_p2b0: assert property (p_p2b0)
		else $error("port two bit 0 not the auxiliary clock");

	// port two bit 1 low out, alternate clock in
	property p_p2b1;
		@(posedge i_clk) disable iff (i_rst)
		st.sel[1][1] |=> !o_p2_pin_out[1] &&
			(o_timer_alt_clock_in == $past(i_p2_pin[1], 2));
	endproperty
	a_p2b1: assert property (p_p2b1)
		else $error("port two bit 1 function wrong");

	// comparator out and capture b in on port two bit 2
	property p_p2b2;
		@(posedge i_clk) disable iff (i_rst)
		st.sel[1][2] |=> (o_p2_pin_out[2] == $past(i_comparator_result))
			&& (o_capture_in_ch0_b == $past(i_p2_pin[2], 2));
	endproperty
	a_p2b2: assert property (p_p2b2)
		else $error("port two bit 2 function wrong");

	// compare b and c on port two bits 3 and 4
	property p_p2b34;
		@(posedge i_clk) disable iff (i_rst)
		(st.sel[1][3] && st.sel[1][4]) |=>
			o_p2_pin_out[4:3] ==
			{$past(i_timer_compare_c), $past(i_timer_compare_b)};
	endproperty
	a_p2b34: assert property (p_p2b34)
		else $error("port two bits 3 and 4 not compare b and c");

	// unbonded bits always read low
	property p_unbonded;
		@(posedge i_clk) disable iff (i_rst)
		level[1][7:6] == 2'b00;
	endproperty
	a_unbonded: assert property (p_unbonded)
		else $error("unbonded bit shows a level");

	// unbonded flags rise only after a software set
	property p_soft_flag;
		@(posedge i_clk) disable iff (i_rst)
		$rose(flag[1][6]) || $rose(flag[1][7]) |->
			$past(setp[1][6]) || $past(setp[1][7]);
	endproperty
	a_soft_flag: assert property (p_soft_flag)
		else $error("unbonded flag set by hardware");

	// without select the pin follows the output register
	property p_gpio_out;
		@(posedge i_clk) disable iff (i_rst)
		!st.sel[0][5] |=> o_p1_pin_out[5] == $past(st.outv[0][5]);
	endproperty
	a_gpio_out: assert property (p_gpio_out)
		else $error("pin does not follow the output register");

	// rising edge with edge select low sets the flag one edge later
	property p_edge_rise;
		@(posedge i_clk) disable iff (i_rst)
		$rose(o_timer_ext_clock_in) && !st.ies[0][0] |=> flag[0][0];
	endproperty
	a_edge_rise: assert property (p_edge_rise)
		else $error("rising edge did not set the flag");

	// interrupt follows enabled flags within one cycle
	property p_irq;
		@(posedge i_clk) disable iff (i_rst)
		(|(flag & st.ie)) |=> o_irq;
	endproperty
	a_irq: assert property (p_irq)
		else $error("enabled flag gave no interrupt");
endmodule : ppfm_top

`default_nettype wire

// ### ppfm_pkg.sv
// shared constants for the port pin function mux and its per-bit cell
`default_nettype none

package ppfm_pkg;
	// register bus geometry
	localparam int          ADDR_W       = 8;   // byte address width
	localparam int          DATA_W       = 32;  // avalon data width
	localparam int          PORT_W       = 8;   // bits per port
	localparam int          P2_PINS      = 6;   // bonded bits of port two
	// address field positions
	localparam int          ALIGN_MSB    = 1;   // must be zero
	localparam int          REG_LSB      = 2;   // register index low bit
	localparam int          REG_MSB      = 4;   // register index high bit
	localparam int          PORT_POS     = 5;   // selects port one or two
	localparam int          TOP_LSB      = 6;   // above map, must be zero
	// register indices inside one port block (byte offset = index * 4)
	localparam logic [2:0]  REG_SEL      = 3'h0; // pin_function_select
	localparam logic [2:0]  REG_DIR      = 3'h1; // pin_direction
	localparam logic [2:0]  REG_OUT      = 3'h2; // pin_output_value
	localparam logic [2:0]  REG_IN       = 3'h3; // pin_input_value, ro
	localparam logic [2:0]  REG_IE       = 3'h4; // pin_irq_enable
	localparam logic [2:0]  REG_IFG      = 3'h5; // pin_irq_flag, w1c
	localparam logic [2:0]  REG_IES      = 3'h6; // pin_edge_select
	localparam logic [2:0]  REG_IFG_SET  = 3'h7; // flag set, w1s
	// reset values
	localparam logic [7:0]  RST_CTRL     = 8'h00; // all control bits
	localparam logic [31:0] RST_RDATA    = 32'h00000000;
	localparam logic [7:0]  RST_OE_N     = 8'hFF; // pins released
endpackage : ppfm_pkg

`default_nettype wire

// ### ppfm_bit.sv
// one port bit: input synchroniser, edge detector and interrupt flag
`timescale 1ns/1ps
`default_nettype none

module ppfm_bit #(
	parameter bit BONDED = 1'b1 // zero for a bit with no pin
) (
	input  wire logic i_clk,      // system clock
	input  wire logic i_rst,      // async reset, active high
	input  wire logic i_pin,      // raw pin level
	input  wire logic i_edge_sel, // low rising, high falling
	input  wire logic i_flag_clr, // software write-one-to-clear
	input  wire logic i_flag_set, // software write-one-to-set
	output logic      o_level,    // synchronised pin level
	output logic      o_flag      // sticky interrupt flag
);
	// whole state of the cell
	typedef struct packed {
		logic s1;   // first synchroniser stage
		logic s2;   // second stage, the used level
		logic s3;   // previous level for edges
		logic flag; // interrupt flag
	} ppfm_bit_t;

	ppfm_bit_t st;      // registered state
	ppfm_bit_t next_st; // next state

	// next state: sync, edge, flag with set winning over clear
	always_comb begin
		logic rise;
		logic fall;
		logic hit;
		rise = 1'b0;
		fall = 1'b0;
		hit  = 1'b0;
		next_st    = st;
		next_st.s1 = BONDED ? i_pin : 1'b0;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		rise = st.s2 & ~st.s3;
		fall = ~st.s2 & st.s3;
		// unbonded bits never see a hardware edge
		hit = BONDED & (i_edge_sel ? fall : rise);
		next_st.flag = (st.flag & ~i_flag_clr) | i_flag_set | hit;
	end

	// state register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_level = st.s2;
	assign o_flag  = st.flag;
endmodule : ppfm_bit

`default_nettype wire

// ### ppfm_far_model.sv
// far-side model: peripheral sources and resolved pin wires
`timescale 1ns/1ps
`default_nettype none

module ppfm_far_model (
	input  wire logic [5:0] i_src,     // {cmp, aux, sub, c, b, a}
	input  wire logic [7:0] i_p1_ext,  // external driver, port one
	input  wire logic [5:0] i_p2_ext,  // external driver, port two
	input  wire logic [7:0] i_p1_out,  // design pin value, port one
	input  wire logic [7:0] i_p1_oe_n, // low while design drives
	input  wire logic [5:0] i_p2_out,  // design pin value, port two
	input  wire logic [5:0] i_p2_oe_n, // low while design drives
	output logic      [7:0] o_p1_pin,  // wire level, port one
	output logic      [5:0] o_p2_pin,  // wire level, port two
	output logic      [5:0] o_src      // peripheral levels to design
);
	// design wins where it drives, else the external driver holds the wire
	assign o_p1_pin = (~i_p1_oe_n & i_p1_out) | (i_p1_oe_n & i_p1_ext);
	assign o_p2_pin = (~i_p2_oe_n & i_p2_out) | (i_p2_oe_n & i_p2_ext);
	// timer, clock system and comparator levels
	assign o_src    = i_src;
endmodule : ppfm_far_model

`default_nettype wire

// ### tb_top.sv
// self-checking bench for the port pin function mux
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic        i_clk  = 1'b0;         // system clock
	logic        i_rst  = 1'b1;         // reset, held at start
	logic [7:0]  addr   = 8'h00;        // bus address
	logic        rd     = 1'b0;         // read strobe
	logic        wr     = 1'b0;         // write strobe
	logic [31:0] wdata  = 32'h00000000; // write data
	logic [3:0]  be     = 4'hF;         // byte lanes
	logic [5:0]  src    = 6'h00;        // {cmp, aux, sub, c, b, a}
	logic [7:0]  p1_ext = 8'h00;        // external drive, port one
	logic [5:0]  p2_ext = 6'h00;        // external drive, port two
	logic [31:0] rdata;                 // read data
	logic        waitreq;               // bus stall
	logic        irq;                   // interrupt line
	logic [7:0]  p1_pin, p1_out, p1_oe_n; // port one wires
	logic [5:0]  p2_pin, p2_out, p2_oe_n; // port two wires
	logic [5:0]  srcw;                  // sources after the model
	logic [5:0]  dest;                  // peripheral destinations
	logic [31:0] got;                   // last read value
	int          fails = 0;             // mismatches
	int          samples_checked = 0;   // comparisons
	int          cycles = 0;            // timeout counter

	ppfm_top u_ppfm_top (.i_clk(i_clk), .i_rst(i_rst),
		.i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wdata), .i_avs_byteenable(be),
		.o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .o_irq(irq),
		.i_p1_pin(p1_pin), .o_p1_pin_out(p1_out), .o_p1_pin_oe_n(p1_oe_n),
		.i_p2_pin(p2_pin), .o_p2_pin_out(p2_out), .o_p2_pin_oe_n(p2_oe_n),
		.i_timer_compare_a(srcw[0]), .i_timer_compare_b(srcw[1]),
		.i_timer_compare_c(srcw[2]), .i_subsystem_clock(srcw[3]),
		.i_auxiliary_clock(srcw[4]), .i_comparator_result(srcw[5]),
		.o_timer_ext_clock_in(dest[0]), .o_capture_in_ch0_a(dest[1]),
		.o_capture_in_ch1_a(dest[2]), .o_capture_in_ch2_a(dest[3]),
		.o_timer_alt_clock_in(dest[4]), .o_capture_in_ch0_b(dest[5]));

	ppfm_far_model u_ppfm_far_model (.i_src(src), .i_p1_ext(p1_ext),
		.i_p2_ext(p2_ext), .i_p1_out(p1_out), .i_p1_oe_n(p1_oe_n),
		.i_p2_out(p2_out), .i_p2_oe_n(p2_oe_n), .o_p1_pin(p1_pin),
		.o_p2_pin(p2_pin), .o_src(srcw));

	// clock, 5 ns period
	always #2.5 i_clk = ~i_clk;

	// ceiling on the run length
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails = fails + 1;
			tally_and_finish();
		end
	end

	// verdict and end of run
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish

	// compare and count
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : check

	// one avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge i_clk);
		addr  <= a;
		wdata <= d;
		wr    <= w;
		rd    <= ~w;
		@(posedge i_clk);
		while (waitreq !== 1'b0) @(posedge i_clk);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus

	// register address of a port block
	function automatic logic [7:0] ra(input logic p, input logic [2:0] r);
		return {2'b00, p, r, 2'b00};
	endfunction : ra

	task automatic wreg(input logic p, input logic [2:0] r,
		input logic [7:0] d);
		bus(1'b1, ra(p, r), {24'h000000, d}, got);
	endtask : wreg

	task automatic creg(input logic p, input logic [2:0] r,
		input logic [7:0] e);
		bus(1'b0, ra(p, r), 32'h00000000, got);
		check(got, {24'h000000, e});
	endtask : creg

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask : wait_cyc

	// expected pin outputs {p2, p1} with every bit on its peripheral
	function automatic logic [31:0] mux_exp(input logic [5:0] s);
		return {18'h00000, 1'b0, s[2], s[1], s[5], 1'b0, s[4],
			s[2], s[1], s[0], s[3], s[2], s[1], s[0], 1'b0};
	endfunction : mux_exp

	// all controls clear, pins released after reset
	task automatic t_reset();
		for (int i = 0; i < 16; i++)
			creg(i[3], i[2:0], 8'h00);
		check({24'h000000, p1_oe_n}, 32'h000000FF);
		check({26'h0000000, p2_oe_n}, 32'h0000003F);
		check({31'h00000000, irq}, 32'h00000000);
	endtask : t_reset

	// unmapped, misaligned, lane-less and read-only writes change nothing
	task automatic t_refuse();
		bus(1'b1, 8'h40, 32'h000000FF, got);
		bus(1'b0, 8'h40, 32'h00000000, got);
		check(got, 32'h00000000);
		bus(1'b1, 8'h01, 32'h000000FF, got);
		be <= 4'h0;
		wreg(1'b0, ppfm_pkg::REG_SEL, 8'hFF);
		be <= 4'hF;
		wreg(1'b0, ppfm_pkg::REG_IN, 8'hFF);
		creg(1'b0, ppfm_pkg::REG_SEL, 8'h00);
		creg(1'b0, ppfm_pkg::REG_IN, 8'h00);
	endtask : t_refuse

	// peripheral outputs reach the pins per bit, direction stays software's
	task automatic t_mux();
		logic [5:0] s;
		wreg(1'b0, ppfm_pkg::REG_SEL, 8'hFF);
		wreg(1'b1, ppfm_pkg::REG_SEL, 8'h3F);
		wreg(1'b0, ppfm_pkg::REG_DIR, 8'hFF);
		wreg(1'b1, ppfm_pkg::REG_DIR, 8'h3F);
		for (int i = 0; i < 7; i++) begin
			s = (i == 6) ? 6'h3F : (6'h01 << i);
			src <= s;
			wait_cyc(3);
			check({18'h00000, p2_out, p1_out}, mux_exp(s));
		end
		wreg(1'b0, ppfm_pkg::REG_SEL, 8'h00);
		wreg(1'b1, ppfm_pkg::REG_SEL, 8'h00);
		wreg(1'b0, ppfm_pkg::REG_OUT, 8'hA5);
		wreg(1'b1, ppfm_pkg::REG_OUT, 8'h2A);
		wait_cyc(3);
		check({18'h00000, p2_out, p1_out}, 32'h00002AA5);
		wreg(1'b0, ppfm_pkg::REG_SEL, 8'hFF);
		wreg(1'b0, ppfm_pkg::REG_DIR, 8'h0F);
		wait_cyc(3);
		check({24'h000000, p1_oe_n}, 32'h000000F0);
		wreg(1'b0, ppfm_pkg::REG_DIR, 8'h00);
		wreg(1'b1, ppfm_pkg::REG_DIR, 8'h00);
	endtask : t_mux

	// pin levels reach input registers and peripheral inputs
	task automatic t_inputs();
		logic [7:0] a;
		logic [5:0] b;
		for (int k = 0; k < 2; k++) begin
			a = (k == 0) ? 8'h55 : 8'hAA;
			b = (k == 0) ? 6'h15 : 6'h2A;
			p1_ext <= a;
			p2_ext <= b;
			wait_cyc(4);
			check({26'h0000000, dest}, {26'h0000000, b[2:1], a[3:0]});
			creg(1'b0, ppfm_pkg::REG_IN, a);
			creg(1'b1, ppfm_pkg::REG_IN, {2'b00, b});
		end
		p1_ext <= 8'h00;
		p2_ext <= 6'h00;
		wait_cyc(4);
		wreg(1'b0, ppfm_pkg::REG_IFG, 8'hFF);
		wreg(1'b1, ppfm_pkg::REG_IFG, 8'hFF);
	endtask : t_inputs

	// edge choice, enable gating and write-one clear
	task automatic t_edge();
		p1_ext <= 8'h01;
		wait_cyc(5);
		creg(1'b0, ppfm_pkg::REG_IFG, 8'h01);
		check({31'h00000000, irq}, 32'h00000000);
		wreg(1'b0, ppfm_pkg::REG_IE, 8'h01);
		wait_cyc(2);
		check({31'h00000000, irq}, 32'h00000001);
		wreg(1'b0, ppfm_pkg::REG_IFG, 8'h01);
		wait_cyc(2);
		check({31'h00000000, irq}, 32'h00000000);
		wreg(1'b0, ppfm_pkg::REG_IES, 8'h01);
		p1_ext <= 8'h00;
		wait_cyc(5);
		creg(1'b0, ppfm_pkg::REG_IFG, 8'h01);
		wreg(1'b0, ppfm_pkg::REG_IFG, 8'h01);
		p1_ext <= 8'h01;
		wait_cyc(5);
		creg(1'b0, ppfm_pkg::REG_IFG, 8'h00);
		wreg(1'b0, ppfm_pkg::REG_IE, 8'h00);
	endtask : t_edge

	// unbonded flags ignore all hardware and answer only to software
	task automatic t_soft();
		wreg(1'b1, ppfm_pkg::REG_IFG, 8'hFF);
		src <= 6'h3F;
		p2_ext <= 6'h3F;
		wait_cyc(5);
		src <= 6'h00;
		p2_ext <= 6'h00;
		wait_cyc(5);
		bus(1'b0, ra(1'b1, ppfm_pkg::REG_IFG), 32'h00000000, got);
		check(got & 32'h000000C0, 32'h00000000);
		wreg(1'b1, ppfm_pkg::REG_IFG_SET, 8'hC0);
		creg(1'b1, ppfm_pkg::REG_IFG_SET, 8'h00);
		bus(1'b0, ra(1'b1, ppfm_pkg::REG_IFG), 32'h00000000, got);
		check(got & 32'h000000C0, 32'h000000C0);
		wreg(1'b1, ppfm_pkg::REG_IE, 8'h40);
		wait_cyc(2);
		check({31'h00000000, irq}, 32'h00000001);
		wreg(1'b1, ppfm_pkg::REG_IFG, 8'hC0);
		wait_cyc(2);
		check({31'h00000000, irq}, 32'h00000000);
	endtask : t_soft

	// main sequence
	initial begin
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		t_reset();
		t_refuse();
		t_mux();
		t_inputs();
		t_edge();
		t_soft();
		tally_and_finish();
	end
endmodule : tb_top

`default_nettype wire
